// [rtl/err_mask_pkg.sv]
// Package: offsets, reset values, field positions and carriers for the error mask bank
package err_mask_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] MODERATE_MASK_OFFSET = 8'h54;
  localparam logic [7:0] STATE_MASK_OFFSET    = 8'h56;
  localparam logic [7:0] COMM_MASK_OFFSET     = 8'h57;
  localparam logic [7:0] READBACK_MASK_OFFSET = 8'h58;

  // Register reset value before nonvolatile defaults land
  localparam logic [7:0] MASK_RESET_VALUE = 8'h00;

  // Moderate-error field positions
  localparam int RESET_OUT_RB_BIT  = 7;
  localparam int IRQ_PIN_RB_BIT    = 6;
  localparam int SYNC_BUS_ERR_BIT  = 4;
  localparam int REG_CRC_ERR_BIT   = 2;
  localparam int SELF_TEST_BIT     = 1;

  // State-machine error field positions
  localparam int MAIN_PWR_ERR_BIT  = 3;
  localparam int MICRO_PWR_ERR_BIT = 2;
  localparam int ORD_SHUTDOWN_BIT  = 1;
  localparam int IMM_SHUTDOWN_BIT  = 0;

  // Communication error field positions
  localparam int P2_ADDR_ERR_BIT   = 7;
  localparam int P2_CRC_ERR_BIT    = 5;
  localparam int HOST_ADDR_ERR_BIT = 3;
  localparam int HOST_CRC_ERR_BIT  = 1;
  localparam int HOST_FRM_ERR_BIT  = 0;

  // Readback error field positions
  localparam int PROC_RST_RB_BIT   = 3;
  localparam int EN_DRV_RB_BIT     = 0;

  // Bits that gate a source in each register; the rest are reserved storage
  localparam logic [7:0] MODERATE_USED = 8'hd6;
  localparam logic [7:0] STATE_USED    = 8'h0f;
  localparam logic [7:0] COMM_USED     = 8'hab;
  localparam logic [7:0] READBACK_USED = 8'h09;

  // One byte-wide image of each of the four mask registers
  typedef struct packed {
    logic [7:0] moderate;
    logic [7:0] state;
    logic [7:0] comm;
    logic [7:0] readback;
  } mask_set_t;

  // Raw event lines from the detectors, same layout as the masks
  typedef mask_set_t err_events_t;

endpackage : err_mask_pkg

// [rtl/mask_gate.sv]
// Gate of one group of error events by its mask byte
`timescale 1ns/1ps
module mask_gate
  import err_mask_pkg::*;
#(
  parameter int          WIDTH = 8,
  parameter logic [7:0]  USED  = 8'hff
) (
  // Event and mask inputs
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic [WIDTH-1:0] mask_in,
  // Gated events
  output logic      [WIDTH-1:0] irq_out
);

  // Mask 0 passes, mask 1 suppresses; reserved positions never pass
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign irq_out[i] = USED[i] & event_in[i] & ~mask_in[i];
    end
  endgenerate

endmodule // mask_gate

// [rtl/error_interrupt_mask_bank.sv]
// Error interrupt mask registers with nonvolatile defaults and event gating
//
// Functional notes
// - Moderate mask bit 7 gates reset-out readback, bit 6 irq-pin readback.
// - Moderate mask bit 4 gates the sync-bus error interrupt.
// - Moderate mask bit 2 gates register CRC, bit 1 self-test fail.
// - State mask at 0x56 gates main/micro power, orderly and immediate shutdown.
// - Comm mask at 0x57 gates second-port addr/CRC and host addr/CRC/frame.
// - Readback mask at 0x58 gates processor reset-out and enable-drive readback.
// - Mask bit 0 lets the source interrupt, 1 suppresses it.
// - Mask defaults come from nonvolatile configuration memory.
// - Moderate, state, comm and readback masks all reset to 0x00 before defaults load.
`timescale 1ns/1ps
module error_interrupt_mask_bank
  import err_mask_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Internal register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  output logic      [7:0]  reg_rd_data,
  output logic             reg_hit,
  // Nonvolatile configuration memory defaults
  input  wire logic        nvm_load,
  input  wire mask_set_t   nvm_defaults,
  // Detector events and gated interrupt requests
  input  wire err_events_t err_events,
  output err_events_t      err_irq,
  output mask_set_t        mask_view
);

  // Mask registers and their next values
  mask_set_t  masks_r;
  mask_set_t  masks_nxt;

  // One-hot register selects, bit 3 down to 0 in struct order
  logic [3:0] rd_sel;
  logic [3:0] wr_sel;

  // Named fields of the moderate-error mask register
  logic       reset_out_readback_irq_mask;
  logic       irq_pin_readback_irq_mask;
  logic       sync_bus_error_irq_mask;
  logic       config_crc_error_irq_mask;
  logic       self_test_fail_irq_mask;

  // Named fields of the state-machine error mask register
  logic       main_processor_power_error_irq_mask;
  logic       micro_power_error_irq_mask;
  logic       orderly_shutdown_irq_mask;
  logic       immediate_shutdown_irq_mask;

  // Named fields of the communication error mask register
  logic       second_port_address_error_irq_mask;
  logic       second_port_crc_error_irq_mask;
  logic       host_port_address_error_irq_mask;
  logic       host_port_crc_error_irq_mask;
  logic       host_port_frame_error_irq_mask;

  // Named fields of the readback error mask register
  logic       processor_reset_out_readback_irq_mask;
  logic       enable_drive_readback_irq_mask;

  // Mask words handed to the gates
  logic [7:0] moderate_gate_mask;
  logic [7:0] state_gate_mask;
  logic [7:0] comm_gate_mask;
  logic [7:0] readback_gate_mask;

  // Address decode shared by the write path and the read mux; one map keeps
  // a register from being writable yet reading back as unmapped
  function automatic logic [3:0] reg_select(input logic [7:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    unique case (addr)
      MODERATE_MASK_OFFSET: sel = 4'h8;
      STATE_MASK_OFFSET:    sel = 4'h4;
      COMM_MASK_OFFSET:     sel = 4'h2;
      READBACK_MASK_OFFSET: sel = 4'h1;
      default:              sel = 4'h0;
    endcase
    return sel;
  endfunction

  // Writes to unmapped addresses select nothing and are dropped
  assign rd_sel = reg_select(reg_addr);
  assign wr_sel = reg_wr_en ? reg_select(reg_addr) : 4'h0;

  // Next mask values. A default load and a software write in one cycle:
  // the write wins on its own register so software never loses its setting,
  // while the load still lands on the other three
  always_comb begin
    masks_nxt = masks_r;
    if (nvm_load) begin
      masks_nxt = nvm_defaults;
    end
    if (wr_sel[3]) begin
      masks_nxt.moderate = reg_wr_data;
    end
    if (wr_sel[2]) begin
      masks_nxt.state = reg_wr_data;
    end
    if (wr_sel[1]) begin
      masks_nxt.comm = reg_wr_data;
    end
    if (wr_sel[0]) begin
      masks_nxt.readback = reg_wr_data;
    end
  end

  // Registers hold 0x00 until the defaults are applied or software writes them, reserved bits too
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      masks_r <= '{MASK_RESET_VALUE, MASK_RESET_VALUE,
                   MASK_RESET_VALUE, MASK_RESET_VALUE};
    end else begin
      masks_r <= masks_nxt;
    end
  end

  // Read mux; every bit reads back as stored, unmapped addresses read zero
  always_comb begin
    reg_rd_data = 8'h00;
    if (rd_sel[3]) begin
      reg_rd_data = masks_r.moderate;
    end
    if (rd_sel[2]) begin
      reg_rd_data = masks_r.state;
    end
    if (rd_sel[1]) begin
      reg_rd_data = masks_r.comm;
    end
    if (rd_sel[0]) begin
      reg_rd_data = masks_r.readback;
    end
  end

  // Hit flag drops for any address outside the four mask registers
  assign reg_hit   = |rd_sel;
  assign mask_view = masks_r;

  // Moderate-error fields picked out of the stored byte
  assign reset_out_readback_irq_mask = masks_r.moderate[RESET_OUT_RB_BIT];
  assign irq_pin_readback_irq_mask   = masks_r.moderate[IRQ_PIN_RB_BIT];
  assign sync_bus_error_irq_mask     = masks_r.moderate[SYNC_BUS_ERR_BIT];
  assign config_crc_error_irq_mask   = masks_r.moderate[REG_CRC_ERR_BIT];
  assign self_test_fail_irq_mask     = masks_r.moderate[SELF_TEST_BIT];

  // State-machine error fields
  assign main_processor_power_error_irq_mask = masks_r.state[MAIN_PWR_ERR_BIT];
  assign micro_power_error_irq_mask          = masks_r.state[MICRO_PWR_ERR_BIT];
  assign orderly_shutdown_irq_mask           = masks_r.state[ORD_SHUTDOWN_BIT];
  assign immediate_shutdown_irq_mask         = masks_r.state[IMM_SHUTDOWN_BIT];

  // Communication error fields
  assign second_port_address_error_irq_mask = masks_r.comm[P2_ADDR_ERR_BIT];
  assign second_port_crc_error_irq_mask     = masks_r.comm[P2_CRC_ERR_BIT];
  assign host_port_address_error_irq_mask   = masks_r.comm[HOST_ADDR_ERR_BIT];
  assign host_port_crc_error_irq_mask       = masks_r.comm[HOST_CRC_ERR_BIT];
  assign host_port_frame_error_irq_mask     = masks_r.comm[HOST_FRM_ERR_BIT];

  // Readback error fields
  assign processor_reset_out_readback_irq_mask = masks_r.readback[PROC_RST_RB_BIT];
  assign enable_drive_readback_irq_mask        = masks_r.readback[EN_DRV_RB_BIT];

  // Moderate gate mask. Reserved positions are forced to 1 so nothing parked
  // there can open a path even for a gate built without its USED map; the
  // price is a few constant bits that fold away
  always_comb begin
    moderate_gate_mask                   = 8'hff;
    moderate_gate_mask[RESET_OUT_RB_BIT] = reset_out_readback_irq_mask;
    moderate_gate_mask[IRQ_PIN_RB_BIT]   = irq_pin_readback_irq_mask;
    moderate_gate_mask[SYNC_BUS_ERR_BIT] = sync_bus_error_irq_mask;
    moderate_gate_mask[REG_CRC_ERR_BIT]  = config_crc_error_irq_mask;
    moderate_gate_mask[SELF_TEST_BIT]    = self_test_fail_irq_mask;
  end

  // State-machine gate mask, reserved positions held suppressed
  always_comb begin
    state_gate_mask                    = 8'hff;
    state_gate_mask[MAIN_PWR_ERR_BIT]  = main_processor_power_error_irq_mask;
    state_gate_mask[MICRO_PWR_ERR_BIT] = micro_power_error_irq_mask;
    state_gate_mask[ORD_SHUTDOWN_BIT]  = orderly_shutdown_irq_mask;
    state_gate_mask[IMM_SHUTDOWN_BIT]  = immediate_shutdown_irq_mask;
  end

  // Communication gate mask, reserved positions held suppressed
  always_comb begin
    comm_gate_mask                    = 8'hff;
    comm_gate_mask[P2_ADDR_ERR_BIT]   = second_port_address_error_irq_mask;
    comm_gate_mask[P2_CRC_ERR_BIT]    = second_port_crc_error_irq_mask;
    comm_gate_mask[HOST_ADDR_ERR_BIT] = host_port_address_error_irq_mask;
    comm_gate_mask[HOST_CRC_ERR_BIT]  = host_port_crc_error_irq_mask;
    comm_gate_mask[HOST_FRM_ERR_BIT]  = host_port_frame_error_irq_mask;
  end

  // Readback gate mask, reserved positions held suppressed
  always_comb begin
    readback_gate_mask                  = 8'hff;
    readback_gate_mask[PROC_RST_RB_BIT] = processor_reset_out_readback_irq_mask;
    readback_gate_mask[EN_DRV_RB_BIT]   = enable_drive_readback_irq_mask;
  end

  // Per-group gating; USED keeps reserved positions out of the requests
  mask_gate #(.WIDTH(8), .USED(MODERATE_USED)) u_gate_moderate (
    .event_in (err_events.moderate),
    .mask_in  (moderate_gate_mask),
    .irq_out  (err_irq.moderate)
  );
  mask_gate #(.WIDTH(8), .USED(STATE_USED)) u_gate_state (
    .event_in (err_events.state),
    .mask_in  (state_gate_mask),
    .irq_out  (err_irq.state)
  );
  mask_gate #(.WIDTH(8), .USED(COMM_USED)) u_gate_comm (
    .event_in (err_events.comm),
    .mask_in  (comm_gate_mask),
    .irq_out  (err_irq.comm)
  );
  mask_gate #(.WIDTH(8), .USED(READBACK_USED)) u_gate_readback (
    .event_in (err_events.readback),
    .mask_in  (readback_gate_mask),
    .irq_out  (err_irq.readback)
  );

endmodule // error_interrupt_mask_bank

// [tb/error_interrupt_mask_bank_sva.sv]
// Checker for the error interrupt mask bank ports
`timescale 1ns/1ps
module error_interrupt_mask_bank_sva
  import err_mask_pkg::*;
(
  // Clock, reset and register port
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_wr_data,
  input wire logic [7:0]  reg_rd_data,
  input wire logic        reg_hit,
  // Defaults, events and masks
  input wire logic        nvm_load,
  input wire mask_set_t   nvm_defaults,
  input wire err_events_t err_events,
  input wire err_events_t err_irq,
  input wire mask_set_t   mask_view
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // A write strobe aimed at one register
  sequence s_wr(logic [7:0] ad); reg_wr_en && reg_addr == ad; endsequence
  property p_gate; err_irq == (err_events & ~mask_view
    & {MODERATE_USED, STATE_USED, COMM_USED, READBACK_USED}); endproperty
  property p_mod; s_wr(MODERATE_MASK_OFFSET) |=> mask_view.moderate == $past(reg_wr_data); endproperty
  property p_st; s_wr(STATE_MASK_OFFSET) |=> mask_view.state == $past(reg_wr_data); endproperty
  property p_cm; s_wr(COMM_MASK_OFFSET) |=> mask_view.comm == $past(reg_wr_data); endproperty
  property p_rb; s_wr(READBACK_MASK_OFFSET) |=> mask_view.readback == $past(reg_wr_data); endproperty
  property p_load; nvm_load && !reg_wr_en |=> mask_view == $past(nvm_defaults); endproperty
  property p_hold; !reg_wr_en && !nvm_load |=> $stable(mask_view); endproperty
  property p_miss; !reg_hit |-> reg_rd_data == 8'h00; endproperty
  property p_rsvd; (err_irq & ~{MODERATE_USED, STATE_USED, COMM_USED, READBACK_USED})
    == 32'h0000_0000; endproperty
  a_gate: assert property (p_gate) else $error("gated irq wrong");
  a_mod: assert property (p_mod) else $error("moderate write lost");
  a_st: assert property (p_st) else $error("state write lost");
  a_cm: assert property (p_cm) else $error("comm write lost");
  a_rb: assert property (p_rb) else $error("readback write lost");
  a_load: assert property (p_load) else $error("defaults not loaded");
  a_hold: assert property (p_hold) else $error("mask changed idle");
  a_miss: assert property (p_miss) else $error("unmapped read nonzero");
  a_rsvd: assert property (p_rsvd) else $error("reserved bit raised irq");
endmodule // error_interrupt_mask_bank_sva

// [tb/error_interrupt_mask_bank_tb_top.sv]
// Self-checking bench for the error interrupt mask bank
`timescale 1ns/1ps
module error_interrupt_mask_bank_tb_top
  import err_mask_pkg::*;
;
  logic        core_clk = 0, rst_b = 0, reg_wr_en = 0, nvm_load = 0, reg_hit;
  logic [7:0]  reg_addr = 0, reg_wr_data = 0, reg_rd_data, a, d;
  logic [31:0] m = 0;
  mask_set_t   nvm_defaults = '0, mask_view;
  err_events_t err_events = '0, err_irq;
  int          bad_count = 0, check_count = 0, cyc = 0, k;
  localparam logic [31:0] USED = {MODERATE_USED, STATE_USED, COMM_USED, READBACK_USED};
  error_interrupt_mask_bank dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_hit(reg_hit), .nvm_load(nvm_load), .nvm_defaults(nvm_defaults),
    .err_events(err_events), .err_irq(err_irq), .mask_view(mask_view));
  always #5 core_clk = ~core_clk;
  // Hang guard: the whole run needs about a hundred cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One strobed write, driven between falling edges
  task automatic wr(input logic [7:0] ad, dv);
    @(negedge core_clk);
    reg_addr = ad; reg_wr_data = dv; reg_wr_en = 1;
    @(negedge core_clk);
    reg_wr_en = 0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(75809));
    repeat (4) @(negedge core_clk);
    rst_b = 1;
    err_events = $urandom;
    #1 chk(mask_view, 0, "reset");
    chk(err_irq, err_events & USED, "open");
    $display("test reset done");
    // Random writes, 0x55 unmapped among them; first ones all ones
    for (int i = 0; i < 40; i++) begin
      a = 8'h54 + 8'($urandom % 5);
      d = (i < 4) ? 8'hff : 8'($urandom);
      wr(a, d);
      k = (a == 8'h54) ? 3 : 32'(8'h58 - a);
      if (a != 8'h55) m[8*k +: 8] = d;
      err_events = $urandom;
      #1 chk(reg_rd_data, (a == 8'h55) ? 0 : d, "read");
      chk(reg_hit, a != 8'h55, "hit");
      chk(mask_view, m, "view");
      chk(err_irq, err_events & ~m & USED, "gate");
    end
    $display("test writes done");
    @(negedge core_clk);
    nvm_defaults = $urandom; nvm_load = 1; m = nvm_defaults;
    @(negedge core_clk);
    nvm_load = 0;
    chk(mask_view, m, "nvm");
    $display("test defaults done");
    // Load and write in one cycle: the write keeps its register, the load the rest
    @(negedge core_clk);
    nvm_defaults = $urandom;
    nvm_load = 1;
    reg_addr = STATE_MASK_OFFSET;
    reg_wr_data = 8'($urandom);
    reg_wr_en = 1;
    m = nvm_defaults;
    m[23:16] = reg_wr_data;
    @(negedge core_clk);
    nvm_load = 0;
    reg_wr_en = 0;
    chk(mask_view, m, "load and write");
    chk(reg_rd_data, m[23:16], "read after mix");
    chk(err_irq, err_events & ~m & USED, "gate after mix");
    $display("test load and write done");
    // A reset in mid-run clears every mask again
    rst_b = 0;
    #1 chk(mask_view, 0, "mid reset");
    @(negedge core_clk);
    rst_b = 1;
    @(negedge core_clk);
    chk(mask_view, 0, "after reset");
    chk(err_irq, err_events & USED, "open again");
    $display("test mid reset done");
    final_report();
  end
endmodule // error_interrupt_mask_bank_tb_top
bind error_interrupt_mask_bank error_interrupt_mask_bank_sva chk_i (.core_clk(core_clk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data), .reg_hit(reg_hit), .nvm_load(nvm_load),
  .nvm_defaults(nvm_defaults), .err_events(err_events), .err_irq(err_irq),
  .mask_view(mask_view));
